// [core/ccs_pkg.sv]
// Function
// - Full-step load-dependent speed mode forces the constant off-time chopper whatever mode is set.
// - An on phase is followed by a fast decay of programmed length unless the fast decay field is zero, not a hysteresis one.
// - The on phase is not timed and ends only when the current comparator reports the target reached.
// - With chopper mode select set, a 4-bit field sets fast decay; zero gives slow decay only.
// - With chopper mode select set, a 4-bit offset adds setting minus three to the sine wave magnitude.
// - A bit picks fast decay end: zero lets the comparator end it early, one ends it by timer only.
// - An 8-bit global scaler applies as value/256, with zero treated as 256.
// - A 5-bit current scale comes from run, hold or adaptive value and is readable by software.
// - Coil target is global/256 times sine/248 times (scale+1)/32 of full scale.
// - Run current, or the lower of adaptive and run when adaptive is enabled, scales the table while moving, hold current while standing still.
`default_nettype none
package ccs_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_NS = 8;
  localparam int BLANK_NS = 800;
  localparam int FD_UNIT_NS = 256;
  localparam int SLOW_NS = 8000;
  localparam logic [10:0] BLANK_CYC = 11'((BLANK_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] FD_UNIT_CYC = 11'((FD_UNIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] SLOW_CYC = 11'((SLOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] CNT_MAX = 11'h7FF;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [3:0] OFS_CHOP = 4'h0;
  localparam logic [3:0] OFS_CURR = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_TGT = 4'hC;
  localparam int CHOP_FD_LSB = 0;
  localparam int CHOP_OFS_LSB = 4;
  localparam int CHOP_MODE_BIT = 8;
  localparam int CHOP_FDEND_BIT = 9;
  localparam int CHOP_FULLSTEP_BIT = 10;
  localparam int CHOP_EN_BIT = 11;
  localparam int CURR_RUN_LSB = 0;
  localparam int CURR_HOLD_LSB = 8;
  localparam int CURR_GS_LSB = 16;
  localparam int CURR_ADAPT_BIT = 24;
  localparam int STAT_CS_LSB = 0;
  localparam int STAT_PHASE_LSB = 8;
  localparam int STAT_STST_BIT = 12;
  localparam logic [31:0] CHOP_MASK = 32'h00000FFF;
  localparam logic [31:0] CURR_MASK = 32'h01FF1F1F;
  localparam logic [31:0] CHOP_RST = 32'h00000134;
  localparam logic [31:0] CURR_RST = 32'h0000101F;

  // ****************************************
  // Scaling constants
  // ****************************************
  localparam logic [3:0] OFFSET_ZERO = 4'h3;
  localparam logic [8:0] GS_FULL = 9'h100;
  localparam logic [8:0] TABLE_AMP = 9'h0F8;
  localparam logic [23:0] FULL_SCALE = 24'h1F0000;

  typedef enum logic [1:0] {
    CCS_IDLE = 2'b00,
    CCS_ON = 2'b01,
    CCS_FAST = 2'b10,
    CCS_SLOW = 2'b11
  } ccs_phase_t;

  // Zero means full scale
  function automatic logic [8:0] ccs_gs_full(input logic [7:0] g);
    return (g == 8'h00) ? GS_FULL : {1'b0, g};
  endfunction

endpackage
`default_nettype wire

// [core/ccs_scale_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface ccs_scale_if;
  logic mode_eff;
  logic [3:0] offset_field;
  logic signed [8:0] sine;
  logic [4:0] run_cur;
  logic [4:0] hold_cur;
  logic [4:0] adapt_cur;
  logic adapt_en;
  logic standstill;
  logic [7:0] gscale;
  logic [4:0] cs_used;
  logic [23:0] target;
  modport calc (
    input mode_eff, offset_field, sine, run_cur, hold_cur, adapt_cur, adapt_en, standstill, gscale,
    output cs_used, target
  );
  modport user (
    output mode_eff, offset_field, sine, run_cur, hold_cur, adapt_cur, adapt_en, standstill, gscale,
    input cs_used, target
  );
endinterface
`default_nettype wire

// [core/ccs_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module ccs_sync (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] meta;

  // Two stages; only the second stage reads the first
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta <= 2'h0;
      sync_out <= 2'h0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// [core/ccs_scale.sv]
`timescale 1ns/100ps
`default_nettype none
module ccs_scale (
  input wire logic sys_clk,
  input wire logic srst,
  ccs_scale_if.calc sc
);
  logic [8:0] mag;
  logic [8:0] amp;
  logic [8:0] gs;
  logic signed [4:0] ofs;
  logic signed [9:0] sum;
  logic [17:0] prod1;
  logic [5:0] cs1;
  logic [4:0] next_cs;
  logic [23:0] next_target;

  // Offset shifts magnitude; clamp keeps it from wrapping below zero
  always_comb
  begin
    mag = sc.sine[8] ? 9'(-sc.sine) : 9'(sc.sine);
    ofs = sc.mode_eff ? ($signed({1'b0, sc.offset_field}) - 5'sd3) : 5'sd0;
    sum = $signed({1'b0, mag}) + 10'(ofs);
    amp = sum[9] ? 9'h000 : sum[8:0];
    gs = ccs_pkg::ccs_gs_full(sc.gscale);
    if (sc.standstill)
      next_cs = sc.hold_cur;
    else if (sc.adapt_en)
      next_cs = (sc.adapt_cur < sc.run_cur) ? sc.adapt_cur : sc.run_cur;
    else
      next_cs = sc.run_cur;
    cs1 = {1'b0, next_cs} + 6'h01;
    prod1 = gs * amp;
    next_target = prod1 * cs1;
  end

  // Result registers; target is a raw product in which FULL_SCALE stands for full scale
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sc.cs_used <= 5'h00;
      sc.target <= 24'h000000;
    end
    else
    begin
      sc.cs_used <= next_cs;
      sc.target <= next_target;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_offset_zero:
    assert property (sc.mode_eff && sc.offset_field == ccs_pkg::OFFSET_ZERO |-> amp == mag)
      else $error("offset three changed amplitude");
  chk_gs_zero_full:
    assert property (sc.gscale == 8'h00 && amp == ccs_pkg::TABLE_AMP && next_cs == 5'h1F
      |=> sc.target == ccs_pkg::FULL_SCALE)
      else $error("global scale zero not full scale");
  chk_target_half:
    assert property (sc.gscale == 8'h80 && amp == ccs_pkg::TABLE_AMP && next_cs == 5'h1F
      |=> sc.target == 24'h0F8000)
      else $error("target formula wrong at half scale");
  chk_cs_hold:
    assert property (sc.standstill |=> sc.cs_used == $past(sc.hold_cur))
      else $error("hold current not used at standstill");
  chk_cs_run:
    assert property (!sc.standstill && !sc.adapt_en |=> sc.cs_used == $past(sc.run_cur))
      else $error("run current not used while moving");
endmodule
`default_nettype wire

// [core/ccs_chopper.sv]
`timescale 1ns/100ps
`default_nettype none
module ccs_chopper (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic chop_cmp_pin,
  input wire logic fd_cmp_pin,
  input wire logic signed [8:0] sine_table_value,
  input wire logic standstill,
  input wire logic [4:0] adaptive_scale,
  output logic bridge_on,
  output logic bridge_fast,
  output logic [4:0] current_scale,
  output logic [23:0] coil_target
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0] chop_cfg;
  logic [31:0] curr_cfg;
  logic [31:0] next_chop;
  logic [31:0] next_curr;
  logic [31:0] next_rdata;
  logic [31:0] rd_val;
  logic next_wait;
  logic cfg_wr;
  logic [1:0] cmp_sync;
  logic cmp_s;
  logic neg_s;
  ccs_pkg::ccs_phase_t phase;
  ccs_pkg::ccs_phase_t next_phase;
  logic [10:0] cnt;
  logic [10:0] next_cnt;
  logic [10:0] fd_len;
  logic next_on;
  logic next_fast;
  logic [3:0] fd;
  logic [3:0] offset_field;
  logic mode_sel;
  logic fd_end_time;
  logic fullstep;
  logic cfg_en;
  logic mode_eff;

  ccs_scale_if sc ();

  // Byte-lane merge used by both writable registers
  function automatic logic [31:0] ccs_be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8 * i +: 8] = new_v[8 * i +: 8];
    end
    return r;
  endfunction

  // ****************************************
  // Field decode
  // ****************************************
  assign fd = chop_cfg[ccs_pkg::CHOP_FD_LSB +: 4];
  assign offset_field = chop_cfg[ccs_pkg::CHOP_OFS_LSB +: 4];
  assign mode_sel = chop_cfg[ccs_pkg::CHOP_MODE_BIT];
  assign fd_end_time = chop_cfg[ccs_pkg::CHOP_FDEND_BIT];
  assign fullstep = chop_cfg[ccs_pkg::CHOP_FULLSTEP_BIT];
  assign cfg_en = chop_cfg[ccs_pkg::CHOP_EN_BIT];

  // Full-step load mode overrides the configured chopper mode
  assign mode_eff = cfg_en & (mode_sel | fullstep);

  // Longer field, longer fast decay, in whole cycle units
  assign fd_len = 11'(fd) * ccs_pkg::FD_UNIT_CYC;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  ccs_sync u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({fd_cmp_pin, chop_cmp_pin}),
    .sync_out(cmp_sync)
  );
  assign cmp_s = cmp_sync[0];
  assign neg_s = cmp_sync[1];

  // ****************************************
  // Current scaling chain
  // ****************************************
  assign sc.mode_eff = mode_eff;
  assign sc.offset_field = offset_field;
  assign sc.sine = sine_table_value;
  assign sc.run_cur = curr_cfg[ccs_pkg::CURR_RUN_LSB +: 5];
  assign sc.hold_cur = curr_cfg[ccs_pkg::CURR_HOLD_LSB +: 5];
  assign sc.adapt_cur = adaptive_scale;
  assign sc.adapt_en = curr_cfg[ccs_pkg::CURR_ADAPT_BIT];
  assign sc.standstill = standstill;
  assign sc.gscale = curr_cfg[ccs_pkg::CURR_GS_LSB +: 8];

  ccs_scale u_scale (
    .sys_clk(sys_clk),
    .srst(srst),
    .sc(sc)
  );

  // Both come from flops inside the scaler
  assign current_scale = sc.cs_used;
  assign coil_target = sc.target;

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // Write lands on the edge where the master sees waitrequest low
  assign cfg_wr = avs_write & ~avs_waitrequest;

  // Read mux; unmapped words read as zero
  always_comb
  begin
    rd_val = 32'h00000000;
    unique case (avs_address)
      ccs_pkg::OFS_CHOP: rd_val = chop_cfg;
      ccs_pkg::OFS_CURR: rd_val = curr_cfg;
      ccs_pkg::OFS_STAT:
      begin
        rd_val[ccs_pkg::STAT_CS_LSB +: 5] = sc.cs_used;
        rd_val[ccs_pkg::STAT_PHASE_LSB +: 2] = phase;
        rd_val[ccs_pkg::STAT_STST_BIT] = standstill;
      end
      ccs_pkg::OFS_TGT: rd_val = {8'h00, sc.target};
      default: rd_val = 32'h00000000;
    endcase
  end

  // One wait cycle per access, then ready for one cycle
  always_comb
  begin
    next_wait = 1'b1;
    next_rdata = avs_readdata;
    next_chop = chop_cfg;
    next_curr = curr_cfg;
    if ((avs_read | avs_write) && avs_waitrequest)
    begin
      next_wait = 1'b0;
      if (avs_read)
        next_rdata = rd_val;
    end
    if (cfg_wr)
    begin
      if (avs_address == ccs_pkg::OFS_CHOP)
        next_chop = ccs_be_merge(chop_cfg, avs_writedata, avs_byteenable) & ccs_pkg::CHOP_MASK;
      if (avs_address == ccs_pkg::OFS_CURR)
        next_curr = ccs_be_merge(curr_cfg, avs_writedata, avs_byteenable) & ccs_pkg::CURR_MASK;
    end
  end

  // Bus and configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      chop_cfg <= ccs_pkg::CHOP_RST;
      curr_cfg <= ccs_pkg::CURR_RST;
    end
    else
    begin
      avs_waitrequest <= next_wait;
      avs_readdata <= next_rdata;
      chop_cfg <= next_chop;
      curr_cfg <= next_curr;
    end
  end

  // ****************************************
  // Constant off-time chopper
  // ****************************************
  // Comparator is ignored for the blank time after each switch,
  // since bridge ringing would otherwise end phases at once
  always_comb
  begin
    next_phase = phase;
    next_cnt = (cnt == ccs_pkg::CNT_MAX) ? cnt : cnt + 11'h001;
    unique case (phase)
      ccs_pkg::CCS_IDLE:
      begin
        next_cnt = 11'h000;
        if (mode_eff)
          next_phase = ccs_pkg::CCS_ON;
      end
      ccs_pkg::CCS_ON:
      begin
        // No timeout: only the comparator ends the on phase
        if (cnt >= ccs_pkg::BLANK_CYC && cmp_s)
        begin
          next_cnt = 11'h000;
          next_phase = (fd == 4'h0) ? ccs_pkg::CCS_SLOW : ccs_pkg::CCS_FAST;
        end
      end
      ccs_pkg::CCS_FAST:
      begin
        if (cnt >= fd_len - 11'h001)
        begin
          next_cnt = 11'h000;
          next_phase = ccs_pkg::CCS_SLOW;
        end
        else if (!fd_end_time && cnt >= ccs_pkg::BLANK_CYC && neg_s)
        begin
          next_cnt = 11'h000;
          next_phase = ccs_pkg::CCS_SLOW;
        end
      end
      ccs_pkg::CCS_SLOW:
      begin
        if (cnt >= ccs_pkg::SLOW_CYC - 11'h001)
        begin
          next_cnt = 11'h000;
          next_phase = ccs_pkg::CCS_ON;
        end
      end
    endcase
    if (!mode_eff)
    begin
      next_phase = ccs_pkg::CCS_IDLE;
      next_cnt = 11'h000;
    end
    next_on = (next_phase == ccs_pkg::CCS_ON);
    next_fast = (next_phase == ccs_pkg::CCS_FAST);
  end

  // Bridge drive registered with the phase so they never disagree
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      phase <= ccs_pkg::CCS_IDLE;
      cnt <= 11'h000;
      bridge_on <= 1'b0;
      bridge_fast <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      cnt <= next_cnt;
      bridge_on <= next_on;
      bridge_fast <= next_fast;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_on_end;
    phase == ccs_pkg::CCS_ON && cmp_s && cnt >= ccs_pkg::BLANK_CYC && mode_eff && !cfg_wr;
  endsequence

  sequence s_fast_cmp;
    phase == ccs_pkg::CCS_FAST && !fd_end_time && neg_s && cnt >= ccs_pkg::BLANK_CYC && mode_eff && !cfg_wr;
  endsequence

  chk_auto_const_off:
    assert property (cfg_en && fullstep && !mode_sel && phase == ccs_pkg::CCS_IDLE
      |=> phase == ccs_pkg::CCS_ON)
      else $error("full-step mode did not start chopper");
  chk_fast_after_on:
    assert property (phase == ccs_pkg::CCS_FAST && $past(phase) != ccs_pkg::CCS_FAST
      |-> $past(phase) == ccs_pkg::CCS_ON)
      else $error("fast decay not entered from on phase");
  chk_on_ends_cmp:
    assert property ($past(phase) == ccs_pkg::CCS_ON && phase != ccs_pkg::CCS_ON && $past(mode_eff)
      |-> $past(cmp_s) && $past(cnt) >= ccs_pkg::BLANK_CYC)
      else $error("on phase ended without comparator");
  chk_fd_zero_slow:
    assert property (s_on_end ##0 fd == 4'h0 |=> phase == ccs_pkg::CCS_SLOW)
      else $error("zero fast decay did not go slow");
  chk_fd_nonzero:
    assert property (s_on_end ##0 fd != 4'h0 |=> phase == ccs_pkg::CCS_FAST && bridge_fast)
      else $error("nonzero fast decay skipped");
  chk_fd_cmp_end:
    assert property (s_fast_cmp |=> phase == ccs_pkg::CCS_SLOW)
      else $error("comparator did not end fast decay");
  chk_fd_time_only:
    assert property (phase == ccs_pkg::CCS_FAST && fd_end_time && mode_eff && !cfg_wr
      && cnt < fd_len - 11'h001 |=> phase == ccs_pkg::CCS_FAST)
      else $error("timer-only fast decay ended early");
  chk_fd_length:
    assert property ($past(phase) == ccs_pkg::CCS_FAST && phase == ccs_pkg::CCS_SLOW
      && $past(fd_end_time) && $past(mode_eff) && !$past(cfg_wr)
      |-> $past(cnt) == $past(fd_len) - 11'h001)
      else $error("fast decay length wrong");
  chk_bus_answer:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one wait cycle");

endmodule
`default_nettype wire

// [bench/ccs_bridge_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****
// Sense comparators behind the bridge
// ****
module ccs_bridge_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic bridge_on,
  input wire logic bridge_fast,
  input wire logic [10:0] on_delay,
  input wire logic [10:0] fd_delay,
  input wire logic fd_use,
  output logic chop_cmp,
  output logic fd_cmp
);
  logic [1:0] prev;
  logic [10:0] cnt;
  // Restart on each phase change, so delays count from phase start
  always_ff @(posedge sys_clk)
  begin
    prev <= {bridge_on, bridge_fast};
    cnt <= (srst || {bridge_on, bridge_fast} != prev) ? 11'h000 : cnt + 11'h001;
  end
  // Trip a set time into the phase; stale count of the last phase never trips
  assign chop_cmp = bridge_on && ({bridge_on, bridge_fast} == prev) && (cnt >= on_delay);
  assign fd_cmp = bridge_fast && fd_use && ({bridge_on, bridge_fast} == prev) && (cnt >= fd_delay);
endmodule
`default_nettype wire

// [bench/tb_const_off_chopper_current_scale.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) \
  begin err_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_const_off_chopper_current_scale;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic chop_cmp_pin;
  logic fd_cmp_pin;
  logic signed [8:0] sine = 9'h000;
  logic standstill = 1'b0;
  logic [4:0] adaptive_scale = 5'h00;
  logic bridge_on;
  logic bridge_fast;
  logic [4:0] current_scale;
  logic [23:0] coil_target;
  logic [10:0] on_delay = 11'h096;
  logic [10:0] fd_delay = 11'h7FF;
  logic fd_use = 1'b0;
  logic [31:0] seed = 32'h00012FC9;
  logic [31:0] q;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  // 125 MHz system clock
  always #4 sys_clk = ~sys_clk;
  ccs_chopper u_dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .chop_cmp_pin(chop_cmp_pin),
    .fd_cmp_pin(fd_cmp_pin),
    .sine_table_value(sine),
    .standstill(standstill),
    .adaptive_scale(adaptive_scale),
    .bridge_on(bridge_on),
    .bridge_fast(bridge_fast),
    .current_scale(current_scale),
    .coil_target(coil_target)
  );
  ccs_bridge_model u_model (
    .sys_clk(sys_clk),
    .srst(srst),
    .bridge_on(bridge_on),
    .bridge_fast(bridge_fast),
    .on_delay(on_delay),
    .fd_delay(fd_delay),
    .fd_use(fd_use),
    .chop_cmp(chop_cmp_pin),
    .fd_cmp(fd_cmp_pin)
  );
  // ****
  // Helpers
  // ****
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cut a hang short; long enough for all chopper cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Offset works on the magnitude and never drives it below zero
  function automatic logic [23:0] exp_tgt(input logic [7:0] g, input int s, input logic [3:0] o,
                                         input logic me, input logic [4:0] cs);
    int a;
    int gg;
    a = (s < 0) ? -s : s;
    if (me)
      a = a + int'(o) - 3;
    if (a < 0)
      a = 0;
    gg = (g == 8'h00) ? 256 : int'(g);
    return 24'(gg * a * (int'(cs) + 1));
  endfunction
  // Hold the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    `CHK("bus_answer", 1'b1, n < 50)
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hF, x);
  endtask
  // Sel 0 on, 1 fast, 2 either; counts edges while it stays at lvl
  task automatic span(input int sel, input logic lvl, output int n);
    n = 0;
    while ((sel == 0 ? bridge_on : sel == 1 ? bridge_fast : (bridge_on | bridge_fast)) === lvl && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // Skip one cycle so the new setting is in force, then time a whole one
  task automatic chop(input logic [11:0] cfg, input int ond, input int fdd, input logic use_fd,
                      input int fexp, input int tol);
    int on_n;
    int fd_n;
    int sl_n;
    int mm;
    on_delay <= 11'(ond);
    fd_delay <= 11'(fdd);
    fd_use <= use_fd;
    wreg(ccs_pkg::OFS_CHOP, {20'h00000, cfg});
    @(posedge sys_clk);
    span(0, 1'b0, on_n);
    if (fexp < 0)
    begin
      `CHK("idle", 3000, on_n)
    end
    else
    begin
      span(0, 1'b1, on_n);
      span(0, 1'b0, on_n);
      span(0, 1'b1, on_n);
      span(1, 1'b1, fd_n);
      span(2, 1'b0, sl_n);
      mm = (ond < 100) ? 100 : ond;
      `CHK("on_len", 1'b1, on_n >= mm && on_n <= mm + 5)
      `CHK("fast_len", 1'b1, fd_n >= fexp - tol && fd_n <= fexp + tol)
      `CHK("slow_len", 1'b1, sl_n >= 999 && sl_n <= 1001)
    end
    $display("test chop %0h done", cfg);
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    int v;
    logic [31:0] r;
    logic [31:0] m;
    logic ss;
    logic [4:0] ad;
    logic [4:0] ecs;
    logic [23:0] et;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, ccs_pkg::OFS_CHOP, 32'h0, 4'hF, q);
    `CHK("chop_rst", ccs_pkg::CHOP_RST, q)
    bus(1'b0, ccs_pkg::OFS_CURR, 32'h0, 4'hF, q);
    `CHK("curr_rst", ccs_pkg::CURR_RST, q)
    wreg(ccs_pkg::OFS_CHOP, 32'hFFFFF0FF);
    bus(1'b0, ccs_pkg::OFS_CHOP, 32'h0, 4'hF, q);
    `CHK("chop_rw", 32'h000000FF, q)
    wreg(4'h1, 32'hFFFFFFFF);
    bus(1'b0, 4'h1, 32'h0, 4'hF, q);
    `CHK("unmapped", 32'h00000000, q)
    bus(1'b1, ccs_pkg::OFS_CURR, 32'h5A5A5A5A, 4'h4, q);
    bus(1'b0, ccs_pkg::OFS_CURR, 32'h0, 4'hF, q);
    `CHK("curr_lane", 32'h005A101F, q)
    $display("test regs done");
    for (int i = 0; i < 24; i++)
    begin
      r = (i == 0) ? 32'h0000001F : (i == 1) ? 32'h0080001F : (rnd() & ccs_pkg::CURR_MASK);
      m = (i < 2) ? 32'h00000130 : (rnd() & 32'h000001F0);
      wreg(ccs_pkg::OFS_CURR, r);
      wreg(ccs_pkg::OFS_CHOP, 32'h00000A04 | m);
      v = (i == 0) ? 248 : (i == 1) ? -248 : int'(rnd() % 32'd497) - 248;
      ss = (i > 2) && seed[20];
      ad = seed[28:24];
      sine <= 9'(v);
      standstill <= ss;
      adaptive_scale <= ad;
      @(posedge sys_clk);
      #1;
      ecs = ss ? r[12:8] : (r[24] && ad < r[4:0]) ? ad : r[4:0];
      `CHK("scale", ecs, current_scale)
      et = exp_tgt(r[23:16], v, m[7:4], m[8], ecs);
      `CHK("target", et, coil_target)
      @(posedge sys_clk);
      bus(1'b0, ccs_pkg::OFS_STAT, 32'h0, 4'hF, q);
      `CHK("stat_cs", ecs, q[4:0])
      `CHK("stat_ss", ss, q[12])
      bus(1'b0, ccs_pkg::OFS_TGT, 32'h0, 4'hF, q);
      `CHK("tgt_reg", {8'h00, et}, q)
    end
    $display("test scale done");
    chop(12'hB34, 150, 2047, 1'b0, 128, 1);
    chop(12'hB30, 150, 2047, 1'b0, 0, 0);
    chop(12'hB31, 700, 2047, 1'b0, 32, 1);
    chop(12'hB3F, 150, 200, 1'b1, 480, 1);
    chop(12'h93F, 150, 200, 1'b1, 203, 3);
    chop(12'h93F, 40, 40, 1'b1, 103, 3);
    chop(12'hA32, 150, 2047, 1'b0, -1, 0);
    chop(12'hE32, 150, 2047, 1'b0, 64, 1);
    wreg(ccs_pkg::OFS_CHOP, 32'h00000000);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("off", 2'b00, {bridge_on, bridge_fast})
    bus(1'b0, ccs_pkg::OFS_STAT, 32'h0, 4'hF, q);
    `CHK("stat_phase", 2'h0, q[9:8])
    end_sim();
  end
endmodule
`default_nettype wire
